/* File: logic/dma_pkg.sv */
/*
 dma channel controller package: register map, field positions, reset values, modes and carriers.
 assumes a 16-bit register port with one-cycle strobes.
*/
package dma_pkg;
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 10;
  localparam int IRQ_W = 7;
  // per-channel block: 8 words per channel, channel at index ch*8
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_REQUEST = 3'h1;
  localparam logic [2:0] OFS_PRIMARY = 3'h2;
  localparam logic [2:0] OFS_SECONDARY = 3'h3;
  localparam logic [2:0] OFS_PERIPH = 3'h4;
  localparam logic [2:0] OFS_COUNT = 3'h5;
  localparam logic [7:0] ADDR_COLLISION = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h41;
  localparam logic [7:0] ADDR_LAST_RAM = 8'h42;
  // control fields
  localparam int CTL_ON = 15;
  localparam int CTL_SIZE = 14;
  localparam int CTL_DIR = 13;
  localparam int CTL_HALF = 12;
  localparam int CTL_NULL_WRITE_SELECT = 11;
  localparam int CTL_ADDRESSING_MODE = 4;
  localparam int CTL_MODE = 0;
  localparam logic [15:0] CTL_MASK = 16'hF833;
  localparam logic [15:0] REQ_MASK = 16'h007F;
  localparam int REQ_FORCE = 15;
  localparam logic [15:0] CNT_MASK = 16'h03FF;
  localparam logic [3:0] LAST_CH_RESET = 4'hF;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    AM_POST_INC = 2'b00,
    AM_NO_INC = 2'b01,
    AM_PERIPH_IND = 2'b10,
    AM_RESERVED = 2'b11
  } addressing_mode_t;

  typedef enum logic [1:0] {
    OP_CONTINUOUS = 2'b00,
    OP_ONE_SHOT = 2'b01,
    OP_CONT_PP = 2'b10,
    OP_ONE_SHOT_PP = 2'b11
  } opmode_t;

  typedef struct packed {
    logic [15:0] control;
    logic force_pending;
    logic [6:0] request_number;
    logic [15:0] primary_start_address;
    logic [15:0] secondary_start_address;
    logic [15:0] peripheral_address;
    logic [9:0] transfer_count;
    logic [9:0] done_count;
    logic [15:0] ram_offset;
    logic pingpong;
    logic halted;
  } chan_t;

  // one transfer request toward the ram/peripheral bus
  typedef struct packed {
    logic valid;
    logic to_periph;
    logic null_write;
    logic byte_size;
    logic [2:0] channel;
    logic [15:0] ram_addr;
    logic [15:0] periph_addr;
  } xfer_t;
endpackage

/* File: logic/dma_channel_controller.sv */
/*
 eight-channel dma controller: registers, request selection, address generation,
 block counting, ping-pong, collision and status flags.
 assumes the transfer bus completes each issued transfer in one cycle and reports collisions.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
// How it works
// (RL1) eight channels, six registers each, shared status
// (RL2) block is transfer count plus one
// (RL3) software leaves address and count alone while enabled
// (RL4) direction set: ram to peripheral
// (RL5) half select picks half or full interrupt
// (RL6) null write adds peripheral write, direction clear
// (RL7) addressing: post-inc, no-inc, peripheral indirect
// (RL8) four operating modes incl. ping-pong one-shot
// (RL9) force bit triggers once, hardware clears
// (RL10) seven-bit select picks one of 128 requests
// (RL11) primary ram start address per channel
// (RL12) secondary ram start address per channel
// (RL13) peripheral address per channel
// (RL14) sticky peripheral write collision flags, upper byte
// (RL15) sticky ram write collision flags, lower byte
// (RL16) last channel reads f until transfer
// (RL17) ping-pong bit shows selected start register
// (RL18) last ram address register
// (RL19) unimplemented bits read zero
// (RL20) ping-pong alternates buffers per block
// (RL21) continuous reloads, one-shot stops
// (RL22) size bit: byte when set
// (RL23) enable gates all requests
`timescale 1ns/1ps
`default_nettype none
module dma_channel_controller (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic [127:0] irq_lines,
  output dma_pkg::xfer_t xfer,
  input wire logic [15:0] periph_index,
  input wire logic periph_collision,
  input wire logic ram_collision,
  output logic [7:0] block_irq
);
  typedef struct packed {
    dma_pkg::chan_t [7:0] ch;
    logic [7:0] pcol;
    logic [7:0] rcol;
    logic [3:0] last_ch;
    logic [15:0] last_ram;
    logic [2:0] rr;
    dma_pkg::xfer_t xfer;
    logic [7:0] irq;
    logic [15:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [127:0] irq_prev_reg;
  logic [127:0] irq_rise;
  logic [7:0] want;
  logic [2:0] pick;
  logic found;
  logic [2:0] wch;
  logic [2:0] wofs;
  logic per_ch;

  assign irq_rise = irq_lines & ~irq_prev_reg;
  assign wch = reg_addr[5:3];
  assign wofs = reg_addr[2:0];
  assign per_ch = (reg_addr[7:6] == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // request gathering and round-robin pick
  always_comb begin
    want = 8'h00;
    for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
      // (RL10) request selection
      // (RL23) enable gating
      want[i] = s_reg.ch[i].control[dma_pkg::CTL_ON] && !s_reg.ch[i].halted &&
                (s_reg.ch[i].force_pending || irq_rise[s_reg.ch[i].request_number]);
    end
    found = 1'b0;
    pick = 3'h0;
    for (int k = 0; k < dma_pkg::NUM_CH; k++) begin
      if (!found && want[3'(s_reg.rr + 3'(k))]) begin
        found = 1'b1;
        pick = 3'(s_reg.rr + 3'(k));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [15:0] ctl;
    logic [15:0] base;
    logic [15:0] step;
    logic [1:0] addressing_mode;
    logic [1:0] opmode;
    logic [9:0] half_pt;
    ctl = 16'h0000;
    base = 16'h0000;
    step = 16'h0000;
    addressing_mode = 2'b00;
    opmode = 2'b00;
    half_pt = 10'h000;
    s_next = s_reg;
    s_next.xfer = '0;
    s_next.irq = 8'h00;
    s_next.rdata = dma_pkg::DATA_ZERO;

    // transfer issue
    if (found) begin
      ctl = s_reg.ch[pick].control;
      addressing_mode = ctl[dma_pkg::CTL_ADDRESSING_MODE +: 2];
      opmode = ctl[dma_pkg::CTL_MODE +: 2];
      // (RL11) (RL12) (RL17) start register by ping-pong state
      base = s_reg.ch[pick].pingpong ? s_reg.ch[pick].secondary_start_address
                                     : s_reg.ch[pick].primary_start_address;
      // (RL22) byte or word stepping
      step = ctl[dma_pkg::CTL_SIZE] ? 16'h0001 : 16'h0002;
      s_next.xfer.valid = 1'b1;
      s_next.xfer.channel = pick;
      s_next.xfer.byte_size = ctl[dma_pkg::CTL_SIZE];
      // (RL4) direction
      s_next.xfer.to_periph = ctl[dma_pkg::CTL_DIR];
      // (RL6) null write only with direction clear
      s_next.xfer.null_write = ctl[dma_pkg::CTL_NULL_WRITE_SELECT] && !ctl[dma_pkg::CTL_DIR];
      // (RL13) peripheral target
      s_next.xfer.periph_addr = s_reg.ch[pick].peripheral_address;
      // (RL7) addressing mode
      unique case (addressing_mode)
        dma_pkg::AM_POST_INC: s_next.xfer.ram_addr = 16'(base + s_reg.ch[pick].ram_offset);
        dma_pkg::AM_NO_INC: s_next.xfer.ram_addr = base;
        dma_pkg::AM_PERIPH_IND: s_next.xfer.ram_addr = base | periph_index;
        dma_pkg::AM_RESERVED: s_next.xfer.ram_addr = base;
      endcase
      if (addressing_mode == dma_pkg::AM_POST_INC) begin
        s_next.ch[pick].ram_offset = 16'(s_reg.ch[pick].ram_offset + step);
      end
      // (RL16) (RL18) last channel and address
      s_next.last_ch = {1'b0, pick};
      s_next.last_ram = s_next.xfer.ram_addr;
      s_next.rr = 3'(pick + 3'h1);
      // (RL9) forced transfer done
      s_next.ch[pick].force_pending = 1'b0;
      // (RL2) count block transfers
      s_next.ch[pick].done_count = 10'(s_reg.ch[pick].done_count + 10'h001);
      half_pt = 10'(s_reg.ch[pick].transfer_count >> 1);
      // (RL5) half-block interrupt
      if (ctl[dma_pkg::CTL_HALF] && s_reg.ch[pick].done_count == half_pt) begin
        s_next.irq[pick] = 1'b1;
      end
      if (s_reg.ch[pick].done_count == s_reg.ch[pick].transfer_count) begin
        if (!ctl[dma_pkg::CTL_HALF]) begin
          s_next.irq[pick] = 1'b1;
        end
        s_next.ch[pick].done_count = 10'h000;
        // (RL21) reload start address after block
        s_next.ch[pick].ram_offset = 16'h0000;
        // (RL20) ping-pong alternation
        if (opmode[1]) begin
          s_next.ch[pick].pingpong = !s_reg.ch[pick].pingpong;
        end
        // (RL8) one-shot stops; one-shot ping-pong after both buffers
        unique case (opmode)
          dma_pkg::OP_CONTINUOUS: s_next.ch[pick].halted = 1'b0;
          dma_pkg::OP_ONE_SHOT: s_next.ch[pick].halted = 1'b1;
          dma_pkg::OP_CONT_PP: s_next.ch[pick].halted = 1'b0;
          dma_pkg::OP_ONE_SHOT_PP: s_next.ch[pick].halted = s_reg.ch[pick].pingpong;
        endcase
        if (opmode == dma_pkg::OP_ONE_SHOT || opmode == dma_pkg::OP_ONE_SHOT_PP) begin
          if (s_next.ch[pick].halted) begin
            s_next.ch[pick].control[dma_pkg::CTL_ON] = 1'b0;
          end
        end
      end
    end

    // register writes
    if (reg_write && per_ch) begin
      unique case (wofs)
        dma_pkg::OFS_CONTROL: begin
          s_next.ch[wch].control = reg_wdata & dma_pkg::CTL_MASK;
          // enabling a channel restarts its block
          if (reg_wdata[dma_pkg::CTL_ON] && !s_reg.ch[wch].control[dma_pkg::CTL_ON]) begin
            s_next.ch[wch].halted = 1'b0;
            s_next.ch[wch].done_count = 10'h000;
            s_next.ch[wch].ram_offset = 16'h0000;
            s_next.ch[wch].pingpong = 1'b0;
          end
        end
        dma_pkg::OFS_REQUEST: begin
          s_next.ch[wch].request_number = reg_wdata[6:0];
          // (RL9) software can set force but never clear it
          if (reg_wdata[dma_pkg::REQ_FORCE]) begin
            s_next.ch[wch].force_pending = 1'b1;
          end
        end
        dma_pkg::OFS_PRIMARY: s_next.ch[wch].primary_start_address = reg_wdata;
        dma_pkg::OFS_SECONDARY: s_next.ch[wch].secondary_start_address = reg_wdata;
        // (RL3) writes while enabled land anyway; software must avoid them
        dma_pkg::OFS_PERIPH: s_next.ch[wch].peripheral_address = reg_wdata;
        dma_pkg::OFS_COUNT: s_next.ch[wch].transfer_count = reg_wdata[9:0];
        default: ;
      endcase
    end
    // (RL14) (RL15) clear-only flags: software writes 0 to clear, set wins
    if (reg_write && reg_addr == dma_pkg::ADDR_COLLISION) begin
      s_next.pcol = s_reg.pcol & reg_wdata[15:8];
      s_next.rcol = s_reg.rcol & reg_wdata[7:0];
    end
    if (s_reg.xfer.valid && periph_collision) begin
      s_next.pcol[s_reg.xfer.channel] = 1'b1;
    end
    if (s_reg.xfer.valid && ram_collision) begin
      s_next.rcol[s_reg.xfer.channel] = 1'b1;
    end

    // (RL1) (RL19) read mux, unused bits zero
    if (reg_read) begin
      if (per_ch) begin
        unique case (wofs)
          dma_pkg::OFS_CONTROL: s_next.rdata = s_reg.ch[wch].control;
          dma_pkg::OFS_REQUEST: s_next.rdata = {s_reg.ch[wch].force_pending, 8'h00,
                                                 s_reg.ch[wch].request_number};
          dma_pkg::OFS_PRIMARY: s_next.rdata = s_reg.ch[wch].primary_start_address;
          dma_pkg::OFS_SECONDARY: s_next.rdata = s_reg.ch[wch].secondary_start_address;
          dma_pkg::OFS_PERIPH: s_next.rdata = s_reg.ch[wch].peripheral_address;
          dma_pkg::OFS_COUNT: s_next.rdata = {6'h00, s_reg.ch[wch].transfer_count};
          default: s_next.rdata = dma_pkg::DATA_ZERO;
        endcase
      end else if (reg_addr == dma_pkg::ADDR_COLLISION) begin
        s_next.rdata = {s_reg.pcol, s_reg.rcol};
      end else if (reg_addr == dma_pkg::ADDR_STATUS) begin
        s_next.rdata[11:8] = s_reg.last_ch;
        for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
          s_next.rdata[i] = s_reg.ch[i].pingpong;
        end
      end else if (reg_addr == dma_pkg::ADDR_LAST_RAM) begin
        s_next.rdata = s_reg.last_ram;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.last_ch <= dma_pkg::LAST_CH_RESET;
      irq_prev_reg <= '0;
    end else begin
      s_reg <= s_next;
      irq_prev_reg <= irq_lines;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign xfer = s_reg.xfer;
  assign block_irq = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_force_clears: assert property (@(posedge ref_clk) disable iff (rst) // RL9
    (found && s_reg.ch[pick].force_pending) |=> !s_reg.ch[$past(pick)].force_pending ||
      (reg_write && $past(reg_write)))
    else $error("force bit not cleared");
  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (rst) // RL23
    (found) |-> s_reg.ch[pick].control[dma_pkg::CTL_ON])
    else $error("disabled channel transferred");
  a_last_ch_track: assert property (@(posedge ref_clk) disable iff (rst) // RL16
    s_reg.xfer.valid |-> s_reg.last_ch == {1'b0, s_reg.xfer.channel})
    else $error("last channel mismatch");
  a_last_ram_track: assert property (@(posedge ref_clk) disable iff (rst) // RL18
    s_reg.xfer.valid |-> s_reg.last_ram == s_reg.xfer.ram_addr)
    else $error("last ram address mismatch");
  a_null_dir: assert property (@(posedge ref_clk) disable iff (rst) // RL6
    s_reg.xfer.null_write |-> !s_reg.xfer.to_periph)
    else $error("null write with ram to peripheral");
  a_pcol_sticky: assert property (@(posedge ref_clk) disable iff (rst) // RL14
    (s_reg.xfer.valid && periph_collision) |=> s_reg.pcol[$past(s_reg.xfer.channel)])
    else $error("peripheral collision lost");
  a_rcol_sticky: assert property (@(posedge ref_clk) disable iff (rst) // RL15
    (s_reg.xfer.valid && ram_collision) |=> s_reg.rcol[$past(s_reg.xfer.channel)])
    else $error("ram collision lost");
  a_count_bound: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    found |-> s_reg.ch[pick].done_count <= s_reg.ch[pick].transfer_count ||
      s_reg.ch[pick].done_count == 10'h000)
    else $error("block count overran");

  ////////////////////////////////////////////////////////////////////////////
  // read path, status, transfer and channel-state checks
  // (RL19) idle read data zero
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst) // RL19
    !$past(reg_read) |-> s_reg.rdata == dma_pkg::DATA_ZERO)
    else $error("read data not zero when idle");

  // (RL19) status upper nibble zero
  a_status_zero: assert property (@(posedge ref_clk) disable iff (rst) // RL19
    ($past(reg_read) && $past(reg_addr) == dma_pkg::ADDR_STATUS) |-> s_reg.rdata[15:12] == 4'h0)
    else $error("status unused bits set");

  // (RL19) count upper bits zero
  a_count_read: assert property (@(posedge ref_clk) disable iff (rst) // RL19
    ($past(reg_read) && $past(reg_addr) == {5'h00, dma_pkg::OFS_COUNT}) |->
      s_reg.rdata[15:10] == 6'h00)
    else $error("count unused bits set");

  // (RL19) control keeps unused bits clear
  a_ctl_unused: assert property (@(posedge ref_clk) disable iff (rst) // RL19
    (s_reg.ch[0].control & ~dma_pkg::CTL_MASK) == 16'h0000)
    else $error("control unused bits set");

  // (RL19) request unused bits zero
  a_req_unused: assert property (@(posedge ref_clk) disable iff (rst) // RL19
    ($past(reg_read) && $past(reg_addr) == {5'h00, dma_pkg::OFS_REQUEST}) |->
      s_reg.rdata[14:7] == 8'h00)
    else $error("request unused bits set");

  // (RL9) force held until served
  a_force_hold: assert property (@(posedge ref_clk) disable iff (rst) // RL9
    (s_reg.ch[0].force_pending && !(found && pick == 3'h0)) |=> s_reg.ch[0].force_pending)
    else $error("force bit dropped early");

  // (RL16) last channel code legal
  a_last_ch_legal: assert property (@(posedge ref_clk) disable iff (rst) // RL16
    s_reg.last_ch <= 4'h7 || s_reg.last_ch == dma_pkg::LAST_CH_RESET)
    else $error("reserved last channel code");

  // (RL17) ping-pong status readback
  a_pp_status: assert property (@(posedge ref_clk) disable iff (rst) // RL17
    ($past(reg_read) && $past(reg_addr) == dma_pkg::ADDR_STATUS) |->
      s_reg.rdata[0] == $past(s_reg.ch[0].pingpong))
    else $error("ping-pong status wrong");

  // (RL4) direction copied to transfer
  a_dir_copy: assert property (@(posedge ref_clk) disable iff (rst) // RL4
    found |=> s_reg.xfer.to_periph == $past(s_reg.ch[pick].control[dma_pkg::CTL_DIR]))
    else $error("direction not carried");

  // (RL13) peripheral address carried
  a_xfer_periph: assert property (@(posedge ref_clk) disable iff (rst) // RL13
    found |=> s_reg.xfer.periph_addr == $past(s_reg.ch[pick].peripheral_address))
    else $error("peripheral address not carried");

  // (RL23) no request, no transfer
  a_idle_no_xfer: assert property (@(posedge ref_clk) disable iff (rst) // RL23
    !found |=> !s_reg.xfer.valid)
    else $error("transfer without request");

  // (RL21) halted channel never picked
  a_halted_idle: assert property (@(posedge ref_clk) disable iff (rst) // RL21
    found |-> !s_reg.ch[pick].halted)
    else $error("halted channel transferred");

  // (RL21) one-shot turns off after block
  a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (rst) // RL21
    (found && s_reg.ch[pick].control[dma_pkg::CTL_MODE +: 2] == dma_pkg::OP_ONE_SHOT &&
      s_reg.ch[pick].done_count == s_reg.ch[pick].transfer_count) |=>
      !s_reg.ch[$past(pick)].control[dma_pkg::CTL_ON] || $past(reg_write))
    else $error("one-shot channel still on");

  // (RL20) buffer flips at block end
  a_pp_toggle: assert property (@(posedge ref_clk) disable iff (rst) // RL20
    (found && s_reg.ch[pick].control[dma_pkg::CTL_MODE + 1] &&
      s_reg.ch[pick].done_count == s_reg.ch[pick].transfer_count) |=>
      s_reg.ch[$past(pick)].pingpong != $past(s_reg.ch[pick].pingpong) || $past(reg_write))
    else $error("ping-pong buffer not switched");

  // (RL2) count wraps at block end
  a_count_wrap: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    (found && s_reg.ch[pick].done_count == s_reg.ch[pick].transfer_count) |=>
      s_reg.ch[$past(pick)].done_count == 10'h000)
    else $error("block count not restarted");

  // (RL7) no-increment keeps start address
  a_noinc_addr: assert property (@(posedge ref_clk) disable iff (rst) // RL7
    (found && s_reg.ch[pick].control[dma_pkg::CTL_ADDRESSING_MODE +: 2] == dma_pkg::AM_NO_INC) |=>
      s_reg.xfer.ram_addr == $past(s_reg.ch[pick].pingpong ?
      s_reg.ch[pick].secondary_start_address : s_reg.ch[pick].primary_start_address))
    else $error("no-increment address moved");

  // (RL1) round robin moves past winner
  a_rr_advance: assert property (@(posedge ref_clk) disable iff (rst) // RL1
    s_reg.xfer.valid |-> s_reg.rr == 3'(s_reg.xfer.channel + 3'h1))
    else $error("round robin not advanced");
endmodule // dma_channel_controller
`default_nettype wire

/* File: test/ram_periph_model.sv */
/*
 peripheral register and dual-port ram side of the dma transfer bus.
 assumes one registered transfer per cycle from the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module ram_periph_model (
  input wire logic ref_clk,
  input wire dma_pkg::xfer_t xfer,
  input wire logic collide,
  output logic [15:0] periph_index,
  output logic periph_collision,
  output logic ram_collision
);
  ////////////////////////////////////////////////////////////////////////////////
  // index changes every cycle so a stale value is never mistaken for a fresh one
  initial periph_index = 16'h0000;
  always @(posedge ref_clk) begin
    periph_index <= periph_index + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // write target
  // null write only meaningful with direction clear, bench keeps to that
  assign periph_collision = xfer.valid & collide & (xfer.to_periph | xfer.null_write);
  assign ram_collision = xfer.valid & collide & ~xfer.to_periph;
endmodule // ram_periph_model
`default_nettype wire

/* File: test/tb.sv */
/*
 testbench for the dma channel controller: register access, transfers, status.
 assumes the register port of the design and the ram/peripheral model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, rst, reg_write, reg_read, collide;
  logic periph_collision, ram_collision;
  logic [7:0] reg_addr, block_irq, b;
  logic [15:0] reg_wdata, reg_rdata, periph_index, p;
  logic [127:0] irq_lines;
  dma_pkg::xfer_t xfer, x;
  int errors, n_checks;

  dma_channel_controller dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq_lines(irq_lines), .xfer(xfer),
    .periph_index(periph_index), .periph_collision(periph_collision),
    .ram_collision(ram_collision), .block_irq(block_irq));
  ram_periph_model partner (.ref_clk(ref_clk), .xfer(xfer), .collide(collide),
    .periph_index(periph_index), .periph_collision(periph_collision),
    .ram_collision(ram_collision));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rc(logic [7:0] a, logic [15:0] exp, string what);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    // read data stand only in this cycle; look before the next edge clears them
    #1;
    check(what, reg_rdata, exp);
    @(posedge ref_clk);
  endtask

  // raise request n (n < 0: wait for a forced transfer) and capture the transfer
  task automatic fire(int n);
    if (n >= 0) irq_lines[n] <= 1'b1;
    #1;
    x = xfer;
    b = block_irq;
    p = periph_index;
    for (int i = 0; i < 8 && x.valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      if (n >= 0) irq_lines[n] <= 1'b0;
      #1;
      x = xfer;
      b = block_irq;
      p = periph_index;
    end
    if (x.valid !== 1'b1) begin
      errors++;
      finish_test();
    end
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    irq_lines = '0;
    collide = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rc(dma_pkg::ADDR_STATUS, 16'h0F00, "status reset");
    rc(dma_pkg::ADDR_LAST_RAM, 16'h0000, "last ram reset");
    wr(8'h38, 16'h7FFF);
    rc(8'h38, 16'h7833, "control mask");
    wr(8'h39, 16'h7FFF);
    rc(8'h39, 16'h007F, "request mask");
    wr(8'h3D, 16'hFFFF);
    rc(8'h3D, 16'h03FF, "count mask");
    wr(8'h43, 16'hFFFF);
    rc(8'h43, 16'h0000, "unmapped");
    // addresses and count set while the channel is still off
    wr(8'h02, 16'h0100);
    wr(8'h03, 16'h0200);
    wr(8'h04, 16'h0030);
    wr(8'h05, 16'h0003);
    wr(8'h01, 16'h0005);
    wr(8'h00, 16'h9002);
    for (int i = 0; i < 4; i++) begin
      collide <= (i == 2);
      fire(5);
      check("xfer ram addr", x.ram_addr, 16'h0100 + 16'(2 * i));
      check("xfer periph addr", x.periph_addr, 16'h0030);
      check("xfer kind", {9'h000, x.valid, x.to_periph, x.null_write, x.byte_size,
        x.channel}, 16'h0040);
      check("half irq", {8'h00, b}, (i == 1) ? 16'h0001 : 16'h0000);
    end
    collide <= 1'b0;
    rc(dma_pkg::ADDR_STATUS, 16'h0001, "status pingpong");
    rc(dma_pkg::ADDR_LAST_RAM, 16'h0106, "last ram");
    fire(5);
    check("second buffer", x.ram_addr, 16'h0200);
    wr(8'h12, 16'h0300);
    wr(8'h14, 16'h0040);
    wr(8'h10, 16'hE001);
    collide <= 1'b1;
    wr(8'h11, 16'h8000);
    fire(-1);
    collide <= 1'b0;
    check("forced kind", {9'h000, x.valid, x.to_periph, x.null_write, x.byte_size,
      x.channel}, 16'h006A);
    check("forced ram", x.ram_addr, 16'h0300);
    check("forced irq", {8'h00, b}, 16'h0004);
    rc(8'h11, 16'h0000, "force cleared");
    rc(8'h10, 16'h6001, "one shot off");
    wr(8'h09, 16'h0009);
    irq_lines[9] <= 1'b1;
    @(posedge ref_clk);
    irq_lines[9] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rc(dma_pkg::ADDR_STATUS, 16'h0201, "status after off");
    rc(dma_pkg::ADDR_COLLISION, 16'h0401, "collisions");
    wr(dma_pkg::ADDR_COLLISION, 16'hFFFE);
    rc(dma_pkg::ADDR_COLLISION, 16'h0400, "collision clear");
    // peripheral index was sampled at the same edge that advanced it, one count before the value captured here
    wr(8'h1A, 16'h0800);
    wr(8'h19, 16'h0014);
    wr(8'h18, 16'h8021);
    fire(20);
    check("indirect ram", x.ram_addr, 16'h0800 | 16'(p - 16'h0001));
    finish_test();
  end
endmodule // tb
`default_nettype wire
